// File: rtl/bcu_branch_control.v
`timescale 1ns/1ps
`default_nettype none
`include "bcu_defines.vh"

// Notes on behaviour
// [RQ1] Calls write next address to link register
// [RQ2] Stored return address has bit0 forced one
// [RQ3] Indirect target with bit0 zero faults
// [RQ4] Target bit0 sets thumb, cleared from address
// [RQ5] Branch ranges: 16MB, conditional 1MB, register any
// [RQ6] Non-secure forms: bit0 zero leaves secure state
// [RQ7] State-changing call pushes return, status, token
// [RQ8] Non-secure forms fault outside secure state
// [RQ9] Compare-branch tests zero, flags untouched
// [RQ10] Software: low registers, forward 4 to 130
// [RQ11] Prefix makes four slots, then or else; here the mask sets one to four
// [RQ12] Software: ever-true prefix uses only then
// [RQ13] Breakpoint inside block always executes
// [RQ14] Exceptions inside block resume correctly
// [RQ15] Software: no prefix, compare-branch, mask ops inside
// [RQ16] Software: PC writers only in last slot
// [RQ17] Conditional branch inside block gets wide range
// [RQ18] Table offset is byte, or twice halfword
// [RQ19] Halfword index doubled; PC base means next
// [RQ20] Table target is next address plus offset
// [RQ21] No branch or prefix writes condition flags
// [RQ22] Slot state advances per instruction, then clears
module bcu_branch_control (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        ins_valid,
  input  wire [3:0]  ins_op,
  input  wire [31:0] ins_pc,
  input  wire        ins_wide,
  input  wire [3:0]  ins_cond,
  input  wire [24:0] ins_ofs,
  input  wire [7:0]  ins_pred,
  input  wire [31:0] ins_rm,
  input  wire [31:0] ins_rn,
  input  wire        ins_rn_pc,
  input  wire [3:0]  ins_flags,
  input  wire [31:0] cur_psr,
  input  wire        exc_take,
  input  wire        rest_valid,
  input  wire [7:0]  rest_pred,
  input  wire        rest_secure,
  input  wire        tbl_ack,
  input  wire [15:0] tbl_data,
  output reg         ins_ready_q,
  output reg         done_q,
  output reg         slot_pass_q,
  output reg         redir_q,
  output reg  [31:0] redir_addr_q,
  output reg         thumb_q,
  output reg         lr_we_q,
  output reg  [31:0] lr_data_q,
  output reg         fault_q,
  output reg         secure_q,
  output reg  [7:0]  pred_state_q,
  output reg         tbl_rd_q,
  output reg  [31:0] tbl_addr_q,
  output reg         tbl_half_q,
  output reg         stk_wr_q,
  output reg  [31:0] stk_data_q
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Condition test on {N,Z,C,V}; reads flags only
  // Code 15 also reads as ever-true; no slot treats it apart
  function cond_ok;
    input [3:0] c;
    input [3:0] f;
    reg         r;
    begin
      case (c[3:1])
        3'h0:    r = f[2];
        3'h1:    r = f[1];
        3'h2:    r = f[3];
        3'h3:    r = f[0];
        3'h4:    r = f[1] & ~f[2];
        3'h5:    r = (f[3] == f[0]);
        3'h6:    r = ~f[2] & (f[3] == f[0]);
        default: r = 1'b1;
      endcase
      // Odd codes invert, except the ever-true pair
      if (c[0] && (c[3:1] != 3'h7))
        cond_ok = ~r;
      else
        cond_ok = r;
    end
  endfunction

  // Next slot: shift mask, clear once exhausted
  // Low three bits zero means the last slot has just been used
  // Top condition bits stay put; the low bit rides in with the mask
  function [7:0] pred_step;
    input [7:0] s;
    begin
      if (s[2:0] == 3'h0)
        pred_step = 8'h00;
      else
        pred_step = {s[7:5], s[3:0], 1'b0};
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [1:0]  st_q;     // Sequencer state
  reg  [31:0] tgt_q;    // Held target or next address for table offset
  reg  [31:0] psr_q;    // Status word awaiting push
  // Only table reads and the secure push leave idle; both drop
  // ready, so decode never has to hold a second instruction

  // ----------------------------------------
  // Decode support
  // ----------------------------------------
  wire        in_blk;   // Inside a predicated block
  wire [3:0]  blk_cond; // Condition of current slot
  wire        pass;     // Slot condition holds
  wire        run;      // Instruction takes effect
  wire [31:0] next_pc;  // Address of next instruction
  wire [31:0] ret_addr; // Link value with bit0 set
  wire [31:0] ofs_ext;  // Extended branch offset
  wire [31:0] rel_tgt;  // PC-relative target
  wire [31:0] ind_tgt;  // Register target, bit0 cleared
  wire [31:0] tbl_base; // Table start
  wire [31:0] tbl_idx;  // Scaled table index
  wire        take;     // Instruction accepted this edge
  wire        wide_rng; // Wide branch range applies
  wire        rn_zero;  // Compare operand is zero

  // Block state: top nibble is the slot's condition, low nibble
  // the then/else mask; any set mask bit means inside a block
  // Kept as one byte so an exception can stack and restore it whole
  assign in_blk   = (pred_state_q[3:0] != 4'h0);
  assign blk_cond = pred_state_q[7:4];
  // Slot condition replaces the branch's own inside a block
  assign pass     = in_blk ? cond_ok(blk_cond, ins_flags) :            // RQ11
                    (ins_op == `BCU_OP_BCOND) ? cond_ok(ins_cond, ins_flags) :
                    1'b1;
  assign run      = pass | (ins_op == `BCU_OP_BREAKPOINT_INSTR);                   // RQ13
  assign next_pc  = ins_pc + (ins_wide ? `BCU_WIDE_LEN : `BCU_NARROW_LEN);
  assign ret_addr = {next_pc[31:1], 1'b1};                             // RQ2
  assign wide_rng = (ins_op != `BCU_OP_BCOND) | in_blk;                // RQ17
  // Compare-branch offsets are forward only, so zero-extend
  assign ofs_ext  = ((ins_op == `BCU_OP_CBZ) || (ins_op == `BCU_OP_COMPARE_NONZERO_BRANCH)) ?
                    {25'h0000000, ins_ofs[6:0]} :
                    wide_rng ? {{7{ins_ofs[24]}}, ins_ofs} :           // RQ5
                    {{11{ins_ofs[20]}}, ins_ofs[20:0]};                // RQ5
  assign rel_tgt  = ins_pc + `BCU_PC_AHEAD + ofs_ext;
  assign ind_tgt  = {ins_rm[31:1], 1'b0};                              // RQ4
  assign tbl_base = ins_rn_pc ? next_pc : ins_rn;                      // RQ19
  assign tbl_idx  = (ins_op == `BCU_OP_TBH) ? {ins_rm[30:0], 1'b0} :   // RQ19
                    ins_rm;
  // Exception entry wins: the instruction waits, slots intact
  assign take     = ins_valid & ins_ready_q & ~exc_take;              // RQ14
  assign rn_zero  = (ins_rn == 32'h00000000);

  // ----------------------------------------
  // Sequencer and outputs
  // ----------------------------------------
  // Pulse outputs live one enabled cycle; with ce low every
  // register holds, pulses included, so a stalled core still
  // sees each pulse once it resumes sampling
  // Flag outputs do not exist: nothing here can write them   // RQ21
  always @(posedge sys_clk) begin
    if (rst) begin
      st_q         <= `BCU_ST_IDLE;
      tgt_q        <= 32'h00000000;
      psr_q        <= 32'h00000000;
      // Ready, thumb and secure come up set; every pulse starts low
      ins_ready_q  <= 1'b1;
      done_q       <= 1'b0;
      slot_pass_q  <= 1'b0;
      redir_q      <= 1'b0;
      redir_addr_q <= 32'h00000000;
      thumb_q      <= 1'b1;
      lr_we_q      <= 1'b0;
      lr_data_q    <= 32'h00000000;
      fault_q      <= 1'b0;
      secure_q     <= `BCU_SECURE_RST;
      pred_state_q <= 8'h00;
      tbl_rd_q     <= 1'b0;
      tbl_addr_q   <= 32'h00000000;
      tbl_half_q   <= 1'b0;
      stk_wr_q     <= 1'b0;
      stk_data_q   <= 32'h00000000;
    end else if (ce) begin
      // Pulses drop unless set below
      done_q   <= 1'b0;
      redir_q  <= 1'b0;
      lr_we_q  <= 1'b0;
      fault_q  <= 1'b0;
      stk_wr_q <= 1'b0;
      case (st_q)
        `BCU_ST_IDLE: begin
          // Nothing is taken while ready is low or an exception enters
          if (take) begin
            done_q      <= 1'b1;
            slot_pass_q <= run;
            // Each covered instruction except a prefix uses one slot
            if (in_blk && (ins_op != `BCU_OP_PRED))
              pred_state_q <= pred_step(pred_state_q);           // RQ22
            if (run) begin
              case (ins_op)
                `BCU_OP_B, `BCU_OP_BCOND: begin
                  // Own or slot condition is already folded into run
                  redir_q      <= 1'b1;                          // RQ5
                  redir_addr_q <= rel_tgt;
                end
                `BCU_OP_DCALL: begin
                  // Link written in the same cycle as the redirect
                  lr_we_q      <= 1'b1;                          // RQ1
                  lr_data_q    <= ret_addr;                      // RQ2
                  redir_q      <= 1'b1;
                  redir_addr_q <= rel_tgt;
                end
                `BCU_OP_IJUMP, `BCU_OP_ICALL: begin
                  // Bit0 low would leave thumb state: illegal use, no link
                  if (!ins_rm[0]) begin
                    fault_q <= 1'b1;                             // RQ3
                  end else begin
                    thumb_q      <= ins_rm[0];                   // RQ4
                    redir_q      <= 1'b1;
                    redir_addr_q <= ind_tgt;                     // RQ4
                    if (ins_op == `BCU_OP_ICALL) begin
                      lr_we_q   <= 1'b1;                         // RQ1
                      lr_data_q <= ret_addr;                     // RQ2
                    end
                  end
                end
                `BCU_OP_NSJUMP, `BCU_OP_NSCALL: begin
                  // Undefined when already non-secure
                  if (!secure_q) begin
                    fault_q <= 1'b1;                             // RQ8
                  end else if (ins_rm[0]) begin
                    // Stays secure, behaves as plain indirect
                    redir_q      <= 1'b1;                        // RQ6
                    redir_addr_q <= ind_tgt;
                    thumb_q      <= 1'b1;
                    if (ins_op == `BCU_OP_NSCALL) begin
                      lr_we_q   <= 1'b1;                         // RQ1
                      lr_data_q <= ret_addr;                     // RQ2
                    end
                  end else if (ins_op == `BCU_OP_NSJUMP) begin
                    secure_q     <= 1'b0;                        // RQ6
                    thumb_q      <= 1'b1;
                    redir_q      <= 1'b1;
                    redir_addr_q <= ind_tgt;
                  end else begin
                    // Return address goes to the secure stack first
                    stk_wr_q    <= 1'b1;                         // RQ7
                    stk_data_q  <= ret_addr;
                    psr_q       <= cur_psr;
                    tgt_q       <= ind_tgt;
                    ins_ready_q <= 1'b0;
                    st_q        <= `BCU_ST_PSR;
                  end
                end
                `BCU_OP_CBZ: begin
                  // Operand compared here, so no flag is written
                  if (rn_zero) begin
                    redir_q      <= 1'b1;                        // RQ9
                    redir_addr_q <= rel_tgt;
                  end
                end
                `BCU_OP_COMPARE_NONZERO_BRANCH: begin
                  // Same test inverted; flags untouched
                  if (!rn_zero) begin
                    redir_q      <= 1'b1;                        // RQ9
                    redir_addr_q <= rel_tgt;
                  end
                end
                `BCU_OP_PRED: begin
                  // Base condition plus then/else mask
                  pred_state_q <= ins_pred;                      // RQ11
                end
                `BCU_OP_TBB, `BCU_OP_TBH: begin
                  // Read held until memory answers
                  tbl_rd_q    <= 1'b1;
                  tbl_addr_q  <= tbl_base + tbl_idx;
                  tbl_half_q  <= (ins_op == `BCU_OP_TBH);
                  // Offset is added to the next address once the entry arrives
                  tgt_q       <= next_pc;                        // RQ20
                  ins_ready_q <= 1'b0;
                  st_q        <= `BCU_ST_TBL;
                end
                default: begin
                  // Breakpoint and others: no control effect, fetch runs on
                  redir_q <= 1'b0;
                end
              endcase
            end
          end
        end
        `BCU_ST_TBL: begin
          // Ready stays low, so no instruction slips past the read
          if (tbl_ack) begin
            tbl_rd_q     <= 1'b0;
            redir_q      <= 1'b1;
            // Unsigned offset only, so always forward
            redir_addr_q <= tbl_half_q ?
                            tgt_q + {15'h0000, tbl_data, 1'b0} :  // RQ18
                            tgt_q + {24'h000000, tbl_data[7:0]}; // RQ18
            ins_ready_q  <= 1'b1;
            st_q         <= `BCU_ST_IDLE;
          end
        end
        `BCU_ST_PSR: begin
          // Partial status word follows the return address
          // Two pushes back to back; the stack side must take both
          stk_wr_q   <= 1'b1;                                    // RQ7
          stk_data_q <= psr_q;
          st_q       <= `BCU_ST_LINK;
        end
        `BCU_ST_LINK: begin
          // Token in link lets a later return come back secure
          // Fetch moves only once both words are on the stack
          lr_we_q      <= 1'b1;                                  // RQ7
          lr_data_q    <= `BCU_RET_TOKEN;
          secure_q     <= 1'b0;                                  // RQ6
          thumb_q      <= 1'b1;
          redir_q      <= 1'b1;
          redir_addr_q <= tgt_q;
          ins_ready_q  <= 1'b1;
          st_q         <= `BCU_ST_IDLE;
        end
        default: begin
          st_q        <= `BCU_ST_IDLE;
          ins_ready_q <= 1'b1;
        end
      endcase
      // Exception return restores slots; wins over any advance
      // Secure state returns with them, as stacked at entry
      if (rest_valid) begin
        pred_state_q <= rest_pred;                               // RQ14
        secure_q     <= rest_secure;
      end
    end
  end

endmodule // bcu_branch_control
`default_nettype wire

// File: rtl/bcu_defines.vh
`ifndef BCU_DEFINES_VH
`define BCU_DEFINES_VH
// ----------------------------------------
// Operation codes from decode
// ----------------------------------------
`define BCU_OP_B       4'h0
`define BCU_OP_BCOND   4'h1
`define BCU_OP_DCALL   4'h2
`define BCU_OP_IJUMP   4'h3
`define BCU_OP_ICALL   4'h4
`define BCU_OP_NSJUMP  4'h5
`define BCU_OP_NSCALL  4'h6
`define BCU_OP_CBZ     4'h7
`define BCU_OP_COMPARE_NONZERO_BRANCH    4'h8
`define BCU_OP_PRED    4'h9
`define BCU_OP_TBB     4'hA
`define BCU_OP_TBH     4'hB
`define BCU_OP_BREAKPOINT_INSTR    4'hC
`define BCU_OP_OTHER   4'hD
// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define BCU_ST_IDLE    2'h0
`define BCU_ST_TBL     2'h1
`define BCU_ST_PSR     2'h2
`define BCU_ST_LINK    2'h3
// ----------------------------------------
// Fixed figures
// ----------------------------------------
`define BCU_PC_AHEAD   32'h00000004
`define BCU_NARROW_LEN 32'h00000002
`define BCU_WIDE_LEN   32'h00000004
`define BCU_COND_EVER  4'hE
`define BCU_RET_TOKEN  32'hFFFFFFFE
`define BCU_SECURE_RST 1'b1
`endif

// File: test/bcu_branch_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcu_defines.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module bcu_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ins_valid,
  input wire logic [3:0]  ins_op,
  input wire logic [31:0] ins_pc,
  input wire logic        ins_wide,
  input wire logic [31:0] ins_rm,
  input wire logic [31:0] ins_rn,
  input wire logic        exc_take,
  input wire logic        ins_ready_q,
  input wire logic        redir_q,
  input wire logic [31:0] redir_addr_q,
  input wire logic        thumb_q,
  input wire logic        lr_we_q,
  input wire logic [31:0] lr_data_q,
  input wire logic        fault_q,
  input wire logic        secure_q,
  input wire logic [7:0]  pred_state_q,
  input wire logic        tbl_rd_q,
  input wire logic        tbl_ack,
  input wire logic        stk_wr_q
);
  // Taken outside a block, so no slot condition can veto it
  wire        tk = ins_valid && ins_ready_q && !exc_take && pred_state_q[3:0] == 4'h0;
  wire [31:0] nx = ins_pc + (ins_wide ? `BCU_WIDE_LEN : `BCU_NARROW_LEN);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  call_link_a: assert property (
    tk && ins_op == `BCU_OP_DCALL |=> lr_we_q && redir_q && lr_data_q == ($past(nx) | 32'h1)) else $error("bad link");
  ind_fault_a: assert property (
    tk && (ins_op == `BCU_OP_IJUMP || ins_op == `BCU_OP_ICALL) && !ins_rm[0] |=> fault_q && !redir_q && !lr_we_q)
    else $error("no fault");
  ind_addr_a: assert property (
    tk && ins_op == `BCU_OP_IJUMP && ins_rm[0] |=> redir_q && thumb_q && redir_addr_q == ($past(ins_rm) & 32'hFFFFFFFE))
    else $error("bad target");
  ns_undef_a: assert property (tk && ins_op == `BCU_OP_NSJUMP && !secure_q |=> fault_q && !redir_q)
    else $error("no undef fault");
  ns_push_a: assert property (
    tk && ins_op == `BCU_OP_NSCALL && !ins_rm[0] && secure_q |=> stk_wr_q ##1 stk_wr_q ##1
    (lr_we_q && lr_data_q == `BCU_RET_TOKEN && !secure_q)) else $error("bad push");
  cmp_zero_a: assert property (tk && ins_op == `BCU_OP_CBZ |=> redir_q == ($past(ins_rn) == 32'h0))
    else $error("bad compare");
  tbl_wait_a: assert property (tbl_rd_q && !tbl_ack |=> tbl_rd_q && !ins_ready_q && !redir_q)
    else $error("table read dropped");
  tbl_done_a: assert property (tbl_rd_q && tbl_ack |=> redir_q && !tbl_rd_q && ins_ready_q)
    else $error("no table redirect");
endmodule // bcu_monitor
bind bcu_branch_control bcu_monitor u_mon (.*);
`default_nettype wire

// File: test/bcu_table_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Table memory beside the branch unit
// ----------------------------------------
module bcu_table_mem (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  dly,
  input  wire logic        tbl_rd_q,
  input  wire logic [31:0] tbl_addr_q,
  input  wire logic        tbl_half_q,
  output var  logic        tbl_ack,
  output var  logic [15:0] tbl_data
);
  logic [3:0] wait_q; // Idle cycles on this read
  // Answer after dly cycles; the bus never holds a stale word
  always @(posedge sys_clk) begin
    if (rst) begin
      tbl_ack <= 1'b0;
      wait_q <= 4'h0;
      tbl_data <= 16'h5A5A;
    end else if (!tbl_ack && tbl_rd_q && wait_q == dly) begin
      tbl_ack <= 1'b1;
      wait_q <= 4'h0;
      tbl_data <= tbl_half_q ? tbl_addr_q[15:0] ^ 16'h00A5 : {~tbl_data[15:8], tbl_addr_q[7:0] ^ 8'hA5};
    end else begin
      tbl_ack <= 1'b0;
      wait_q <= (tbl_rd_q && !tbl_ack) ? wait_q + 4'h1 : 4'h0;
      tbl_data <= ~tbl_data;
    end
  end
endmodule // bcu_table_mem
`default_nettype wire

// File: test/tb_branch_control_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcu_defines.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_branch_control_unit;
  logic        sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, ins_valid = 1'b0, ins_wide = 1'b0, ins_rn_pc = 1'b0;
  logic        exc_take = 1'b0, rest_valid = 1'b0, rest_secure = 1'b1;
  logic [3:0]  ins_op = 4'h0, ins_cond = 4'h0, ins_flags = 4'h0, dly = 4'h0;
  logic [7:0]  ins_pred = 8'h00, rest_pred = 8'h00;
  logic [24:0] ins_ofs = 25'h0;
  logic [31:0] ins_pc = 32'h0, ins_rm = 32'h0, ins_rn = 32'h0, cur_psr = 32'h01000000;
  wire         ins_ready_q, done_q, slot_pass_q, redir_q, thumb_q, lr_we_q, fault_q, secure_q;
  wire         tbl_rd_q, tbl_half_q, stk_wr_q, tbl_ack;
  wire [7:0]   pred_state_q;
  wire [15:0]  tbl_data;
  wire [31:0]  redir_addr_q, lr_data_q, tbl_addr_q, stk_data_q;
  int          miscompares = 0, tests_run = 0;
  bcu_branch_control uut (.*);
  bcu_table_mem tmem (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic test_done;
    $display("compared %0d mismatched %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge sys_clk) rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK("secure", 1'b1, secure_q)
    `CHK("pred", 8'h00, pred_state_q)
  endtask
  // Offer one instruction, then look at the answer once it has landed
  task automatic issue(input logic [3:0] op, input logic [31:0] pc, rm, rn, input logic [24:0] ofs);
    @(posedge sys_clk);
    ins_op <= op;
    ins_pc <= pc;
    ins_rm <= rm;
    ins_rn <= rn;
    ins_ofs <= ofs;
    ins_wide <= op == `BCU_OP_DCALL || op == `BCU_OP_TBB || op == `BCU_OP_TBH;
    ins_valid <= 1'b1;
    @(posedge sys_clk) ins_valid <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic wait_redir;
    for (int i = 0; i < 40 && redir_q !== 1'b1; i++) @(negedge sys_clk);
    `CHK("redir", 1'b1, redir_q)
  endtask
  task automatic t_branch;
    issue(`BCU_OP_DCALL, 32'h1000, 32'h0, 32'h0, 25'h1000000);
    `CHK("lr", 32'h00001005, lr_data_q)
    `CHK("back", 32'hFF001004, redir_addr_q)
    issue(`BCU_OP_DCALL, 32'h1000, 32'h0, 32'h0, 25'h0FFFFFE);
    `CHK("fwd", 32'h01001002, redir_addr_q)
    issue(`BCU_OP_B, 32'h3000, 32'h0, 32'h0, 25'h0FFFFFE);
    `CHK("b", 33'h101003002, {redir_q, redir_addr_q})
    issue(`BCU_OP_ICALL, 32'h2000, 32'h5001, 32'h0, 25'h0);
    `CHK("lr", 32'h00002003, lr_data_q)
    issue(`BCU_OP_IJUMP, 32'h100, 32'h4003, 32'h0, 25'h0);
    `CHK("tgt", 32'h00004002, redir_addr_q)
    issue(`BCU_OP_ICALL, 32'h200, 32'h4000, 32'h0, 25'h0);
    `CHK("fault", 2'b10, {fault_q, lr_we_q})
    for (int i = 0; i < 4; i++) begin
      issue(i[1] ? `BCU_OP_COMPARE_NONZERO_BRANCH : `BCU_OP_CBZ, 32'h300, 32'h0, {29'h0, i[0], 2'h0}, 25'h7E);
      `CHK("cmp", i[1] ^ !i[0], redir_q)
    end
    $display("branches end");
  endtask
  // Three-slot block: EQ, EQ, NE with Z clear; no branch inside
  task automatic t_pred;
    @(posedge sys_clk) ins_pred <= 8'h06;
    issue(`BCU_OP_PRED, 32'h500, 32'h0, 32'h0, 25'h0);
    @(posedge sys_clk) ins_op <= `BCU_OP_OTHER;
    ins_valid <= 1'b1;
    exc_take <= 1'b1;
    @(posedge sys_clk) ins_valid <= 1'b0;
    exc_take <= 1'b0;
    @(negedge sys_clk);
    `CHK("held", 2'b01, {done_q, pred_state_q[3:0] != 4'h0})
    issue(`BCU_OP_OTHER, 32'h502, 32'h0, 32'h0, 25'h0);
    `CHK("slot1", 1'b0, slot_pass_q)
    issue(`BCU_OP_BREAKPOINT_INSTR, 32'h504, 32'h0, 32'h0, 25'h0);
    `CHK("breakpoint_instr", 1'b1, slot_pass_q)
    issue(`BCU_OP_OTHER, 32'h506, 32'h0, 32'h0, 25'h0);
    `CHK("slot3", 2'b10, {slot_pass_q, pred_state_q[3:0] != 4'h0})
    // Exception return drops the core back into the last slot
    @(posedge sys_clk) rest_pred <= 8'h18;
    rest_valid <= 1'b1;
    @(posedge sys_clk) rest_valid <= 1'b0;
    @(negedge sys_clk);
    `CHK("rest", 8'h18, pred_state_q)
    issue(`BCU_OP_OTHER, 32'h506, 32'h0, 32'h0, 25'h0);
    `CHK("resume", 9'h100, {slot_pass_q, pred_state_q})
    // Own condition outside a block uses the short signed range
    @(posedge sys_clk) ins_flags <= 4'h4;
    ins_cond <= 4'h0;
    issue(`BCU_OP_BCOND, 32'h2000, 32'h0, 32'h0, 25'h0100000);
    `CHK("bcond", 33'h1FFF02004, {redir_q, redir_addr_q})
    @(posedge sys_clk) ins_cond <= 4'h1;
    issue(`BCU_OP_BCOND, 32'h2000, 32'h0, 32'h0, 25'h0100000);
    `CHK("bnot", 2'b00, {redir_q, slot_pass_q})
    // Same offset in the last slot of a block reaches forward
    @(posedge sys_clk) ins_pred <= 8'h08;
    issue(`BCU_OP_PRED, 32'h1FFE, 32'h0, 32'h0, 25'h0);
    issue(`BCU_OP_BCOND, 32'h2000, 32'h0, 32'h0, 25'h0100000);
    `CHK("bwide", 34'h200102004, {redir_q, pred_state_q[3:0] != 4'h0, redir_addr_q})
    // Ever-true prefix with no else slot; covered code is unconditional
    @(posedge sys_clk) ins_pred <= 8'hE8;
    ins_flags <= 4'h0;
    issue(`BCU_OP_PRED, 32'h600, 32'h0, 32'h0, 25'h0);
    issue(`BCU_OP_OTHER, 32'h602, 32'h0, 32'h0, 25'h0);
    `CHK("ever", 2'b10, {slot_pass_q, pred_state_q[3:0] != 4'h0})
    $display("block end");
  endtask
  task automatic t_tbl;
    @(posedge sys_clk) ins_rn_pc <= 1'b1;
    dly <= 4'h3;
    issue(`BCU_OP_TBH, 32'h100, 32'h3, 32'hDEAD0000, 25'h0);
    `CHK("taddr", 34'h20000010A, {tbl_rd_q, ins_ready_q, tbl_addr_q})
    wait_redir;
    `CHK("tbh", 32'h00000462, redir_addr_q)
    @(posedge sys_clk) ins_rn_pc <= 1'b0;
    dly <= 4'h0;
    issue(`BCU_OP_TBB, 32'h300, 32'h5, 32'h2000, 25'h0);
    wait_redir;
    `CHK("tbb", 32'h000003A4, redir_addr_q)
    $display("tables end");
  endtask
  task automatic t_ns;
    issue(`BCU_OP_NSCALL, 32'h400, 32'h6000, 32'h0, 25'h0);
    `CHK("ret", 33'h100000403, {stk_wr_q, stk_data_q})
    @(negedge sys_clk);
    `CHK("psr", 33'h101000000, {stk_wr_q, stk_data_q})
    @(negedge sys_clk);
    `CHK("token", `BCU_RET_TOKEN, lr_data_q)
    `CHK("state", 1'b0, secure_q)
    issue(`BCU_OP_NSJUMP, 32'h6000, 32'h7001, 32'h0, 25'h0);
    `CHK("undef", 1'b1, fault_q)
    // Exception return brings the secure state back
    @(posedge sys_clk) rest_pred <= 8'h00;
    rest_valid <= 1'b1;
    @(posedge sys_clk) rest_valid <= 1'b0;
    @(negedge sys_clk);
    `CHK("back", 9'h100, {secure_q, pred_state_q})
    issue(`BCU_OP_NSJUMP, 32'h500, 32'h8000, 32'h0, 25'h0);
    `CHK("nsjump", 34'h200008000, {redir_q, secure_q, redir_addr_q})
    do_reset;
    $display("secure end");
  endtask
  initial begin
    do_reset;
    t_branch;
    t_pred;
    t_tbl;
    t_ns;
    test_done;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end
endmodule // tb_branch_control_unit
`default_nettype wire
